// ---- hmlc_config.v ----
// Mode, trigger pin and loop configuration registers behind a two-wire slave.
`timescale 1ns/10ps
`default_nettype none
`include "hmlc_defs.vh"

module hmlc_config #(
  parameter [6:0] OWN_ADDR = `HMLC_OWN_ADDR_DEFAULT,
  parameter       PERW     = 10
) (
  input  wire            CLK,
  input  wire            RST,
  input  wire            SCL,
  input  wire            SDA_IN,
  output wire            SDA_OUT,
  output reg             SDA_OE,
  input  wire            TRIG_IN,
  output wire            TRIG_OUT,
  output reg             TRIG_OE,
  input  wire            INT_REQ,
  input  wire            GO_WRITE,
  input  wire            GO_VALUE,
  input  wire            PROCESS_BUSY,
  input  wire            PLAYING,
  input  wire            STANDBY_TIMER,
  input  wire            BRAKE_DONE,
  input  wire [7:0]      SAMPLE,
  input  wire [PERW-1:0] PERIOD_MEAS,
  input  wire            PERIOD_VALID,
  output wire [PERW-1:0] PERIOD_REPORT,
  output reg  [1:0]      MODE,
  output reg  [2:0]      COMP_PERCENT,
  output reg             ACTUATOR_LRA,
  output reg             DRIVE_CLOSED_LOOP,
  output reg             SAMPLE_BRAKE,
  output reg             HYBRID_LOOP,
  output reg             SLOPE_CHECK_EN,
  output reg             START_PULSE,
  output reg             CANCEL_PULSE,
  output reg             STANDBY_PULSE,
  output reg             BRAKE_REQ
);

  // ****************************************************************
  // Two-wire slave states
  // ****************************************************************
  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_ADDR  = 3'h1;
  localparam [2:0] S_AACK  = 3'h2;
  localparam [2:0] S_WBYTE = 3'h3;
  localparam [2:0] S_WACK  = 3'h4;
  localparam [2:0] S_RBYTE = 3'h5;
  localparam [2:0] S_RACK  = 3'h6;

  localparam       C_RUN   = 1'b0;
  localparam       C_BRAKE = 1'b1;

  reg  [2:0] st_reg;
  reg  [2:0] cnt_reg;
  reg  [7:0] sh_reg;
  reg  [7:0] ptr_reg;
  reg        ptr_set_reg;
  reg        done_reg;
  reg        rd_reg;
  reg        scl_reg;
  reg        sda_reg;
  reg  [7:0] mode_trig_reg;
  reg  [7:0] act_loop_reg;
  reg        abort_reg;
  reg        trig_reg;
  reg        ctl_reg;

  wire       scl_rise = SCL & ~scl_reg;
  wire       scl_fall = ~SCL & scl_reg;
  wire       start_c  = SCL & scl_reg & sda_reg & ~SDA_IN;
  wire       stop_c   = SCL & scl_reg & ~sda_reg & SDA_IN;
  wire       bcast_en = mode_trig_reg[`HMLC_BCAST_EN_BIT];
  wire       own_hit  = (sh_reg[7:1] == OWN_ADDR);
  // A broadcast read would collide with other drivers, so only writes answer it.
  wire       bc_hit   = bcast_en & ~sh_reg[0] & (sh_reg[7:1] == `HMLC_BCAST_ADDR);
  wire [1:0] pin_fn   = mode_trig_reg[`HMLC_PIN_HI:`HMLC_PIN_LO];
  wire [7:0] rd_byte  = (ptr_reg == `HMLC_ADDR_MODE_TRIG) ? mode_trig_reg :
                        (ptr_reg == `HMLC_ADDR_ACT_LOOP) ? act_loop_reg :
                        `HMLC_READ_UNMAPPED;

  assign SDA_OUT  = 1'b0;
  assign TRIG_OUT = 1'b0;

  // ****************************************************************
  // Two-wire slave and register file
  // ****************************************************************
  always @(posedge CLK) begin
    if (RST) begin
      st_reg        <= S_IDLE;
      cnt_reg       <= 3'h7;
      sh_reg        <= 8'h00;
      ptr_reg       <= 8'h00;
      ptr_set_reg   <= 1'b0;
      done_reg      <= 1'b0;
      rd_reg        <= 1'b0;
      scl_reg       <= 1'b1;
      sda_reg       <= 1'b1;
      SDA_OE        <= 1'b0;
      mode_trig_reg <= `HMLC_RST_MODE_TRIG;
      act_loop_reg  <= `HMLC_RST_ACT_LOOP;
      abort_reg     <= 1'b0;
    end else begin
      scl_reg   <= SCL;
      sda_reg   <= SDA_IN;
      abort_reg <= 1'b0;
      if (start_c) begin
        st_reg   <= S_ADDR;
        cnt_reg  <= 3'h7;
        done_reg <= 1'b0;
        SDA_OE   <= 1'b0;
      end else if (stop_c) begin
        st_reg <= S_IDLE;
        SDA_OE <= 1'b0;
      end else begin
        case (st_reg)
          S_ADDR, S_WBYTE: begin
            if (scl_rise) begin
              sh_reg   <= {sh_reg[6:0], SDA_IN};
              cnt_reg  <= cnt_reg - 3'h1;
              done_reg <= (cnt_reg == 3'h0);
            end else if (scl_fall && done_reg) begin
              done_reg <= 1'b0;
              if (st_reg == S_ADDR) begin
                if (own_hit || bc_hit) begin
                  st_reg <= S_AACK;
                  rd_reg <= sh_reg[0];
                  SDA_OE <= 1'b1;
                end else begin
                  st_reg <= S_IDLE;
                end
              end else begin
                st_reg <= S_WACK;
                SDA_OE <= 1'b1;
                if (!ptr_set_reg) begin
                  ptr_reg     <= sh_reg;
                  ptr_set_reg <= 1'b1;
                end else begin
                  ptr_reg <= ptr_reg + 8'h01;
                  if (ptr_reg == `HMLC_ADDR_MODE_TRIG) begin
                    mode_trig_reg <= sh_reg;
                    if (PROCESS_BUSY &&
                        (sh_reg[`HMLC_PIN_HI:`HMLC_MODE_LO] !=
                         mode_trig_reg[`HMLC_PIN_HI:`HMLC_MODE_LO])) begin
                      abort_reg <= 1'b1;
                    end
                  end else if (ptr_reg == `HMLC_ADDR_ACT_LOOP) begin
                    act_loop_reg <= sh_reg;
                  end
                end
              end
            end
          end
          S_AACK, S_RACK: begin
            if (scl_rise && st_reg == S_RACK && SDA_IN) begin
              st_reg <= S_IDLE;
            end else if (scl_fall) begin
              cnt_reg <= 3'h7;
              if (rd_reg) begin
                st_reg  <= S_RBYTE;
                SDA_OE  <= ~rd_byte[7];
                sh_reg  <= {rd_byte[6:0], 1'b0};
                ptr_reg <= ptr_reg + 8'h01;
              end else begin
                st_reg      <= S_WBYTE;
                SDA_OE      <= 1'b0;
                ptr_set_reg <= 1'b0;
              end
            end
          end
          S_WACK: begin
            if (scl_fall) begin
              st_reg  <= S_WBYTE;
              cnt_reg <= 3'h7;
              SDA_OE  <= 1'b0;
            end
          end
          S_RBYTE: begin
            if (scl_fall) begin
              if (cnt_reg == 3'h0) begin
                st_reg <= S_RACK;
                SDA_OE <= 1'b0;
              end else begin
                SDA_OE  <= ~sh_reg[7];
                sh_reg  <= {sh_reg[6:0], 1'b0};
                cnt_reg <= cnt_reg - 3'h1;
              end
            end
          end
          default: begin
            st_reg <= S_IDLE;
            SDA_OE <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Configuration decode
  // ****************************************************************
  always @(posedge CLK) begin
    if (RST) begin
      MODE              <= 2'h0;
      COMP_PERCENT      <= `HMLC_COMP_CODE1;
      ACTUATOR_LRA      <= 1'b1;
      DRIVE_CLOSED_LOOP <= 1'b1;
      SAMPLE_BRAKE      <= 1'b0;
      HYBRID_LOOP       <= 1'b0;
      SLOPE_CHECK_EN    <= 1'b0;
      TRIG_OE           <= 1'b0;
    end else begin
      MODE <= mode_trig_reg[`HMLC_MODE_HI:`HMLC_MODE_LO];
      case (mode_trig_reg[`HMLC_COMP_HI:`HMLC_COMP_LO])
        2'h0:    COMP_PERCENT <= `HMLC_COMP_CODE0;
        2'h1:    COMP_PERCENT <= `HMLC_COMP_CODE1;
        2'h2:    COMP_PERCENT <= `HMLC_COMP_CODE2;
        default: COMP_PERCENT <= `HMLC_COMP_CODE3;
      endcase
      ACTUATOR_LRA <= act_loop_reg[`HMLC_ACT_TYPE_BIT];
      // Non-positive samples close the loop so the brake can act on them.
      SAMPLE_BRAKE <= act_loop_reg[`HMLC_OPEN_LOOP_BIT] & act_loop_reg[`HMLC_OL_BRAKE_BIT] &
                      (SAMPLE[7] | (SAMPLE == 8'h00));
      DRIVE_CLOSED_LOOP <= ~act_loop_reg[`HMLC_OPEN_LOOP_BIT] |
                           (act_loop_reg[`HMLC_OL_BRAKE_BIT] &
                            (SAMPLE[7] | (SAMPLE == 8'h00)));
      HYBRID_LOOP    <= act_loop_reg[`HMLC_HYBRID_BIT];
      SLOPE_CHECK_EN <= act_loop_reg[`HMLC_HYBRID_BIT] & act_loop_reg[`HMLC_SLOPE_BIT];
      TRIG_OE        <= (pin_fn == `HMLC_PIN_INTERRUPT) & INT_REQ;
    end
  end

  // ****************************************************************
  // Trigger, go bit and standby control
  // ****************************************************************
  wire trig_rise = TRIG_IN & ~trig_reg;
  wire trig_fall = ~TRIG_IN & trig_reg;
  wire go_ok     = (pin_fn == `HMLC_PIN_PULSE) | (pin_fn == `HMLC_PIN_INTERRUPT);
  wire pin_start = ((pin_fn == `HMLC_PIN_PULSE) | (pin_fn == `HMLC_PIN_LEVEL)) & trig_rise;
  wire stby_req  = STANDBY_TIMER | ((pin_fn == `HMLC_PIN_LEVEL) & trig_fall);
  wire brk_stby  = act_loop_reg[`HMLC_BRK_STBY_BIT];

  always @(posedge CLK) begin
    if (RST) begin
      trig_reg      <= 1'b0;
      ctl_reg       <= C_RUN;
      START_PULSE   <= 1'b0;
      CANCEL_PULSE  <= 1'b0;
      STANDBY_PULSE <= 1'b0;
      BRAKE_REQ     <= 1'b0;
    end else begin
      trig_reg      <= TRIG_IN;
      START_PULSE   <= ~PROCESS_BUSY & ~abort_reg &
                       (pin_start | (go_ok & GO_WRITE & GO_VALUE));
      CANCEL_PULSE  <= PROCESS_BUSY & go_ok & GO_WRITE & ~GO_VALUE;
      STANDBY_PULSE <= 1'b0;
      // A configuration abort overrides any brake in progress.
      if (abort_reg) begin
        ctl_reg       <= C_RUN;
        BRAKE_REQ     <= 1'b0;
        STANDBY_PULSE <= 1'b1;
      end else begin
        case (ctl_reg)
          C_RUN: begin
            if (stby_req) begin
              if (brk_stby && PLAYING) begin
                ctl_reg   <= C_BRAKE;
                BRAKE_REQ <= 1'b1;
              end else begin
                STANDBY_PULSE <= 1'b1;
              end
            end
          end
          default: begin
            if (BRAKE_DONE) begin
              ctl_reg       <= C_RUN;
              BRAKE_REQ     <= 1'b0;
              STANDBY_PULSE <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Resonance period report
  // ****************************************************************
  hmlc_period_avg #(
    .WIDTH      (PERW),
    .LOG2_DEPTH (2)
  ) u_period (
    .clk        (CLK),
    .rst        (RST),
    .meas       (PERIOD_MEAS),
    .meas_valid (PERIOD_VALID),
    .avg_dis    (mode_trig_reg[`HMLC_AVG_DIS_BIT]),
    .report     (PERIOD_REPORT)
  );

endmodule

`default_nettype wire

// ---- hmlc_defs.vh ----
// Constants shared by the mode, trigger and loop configuration block.
`ifndef HMLC_DEFS_VH
`define HMLC_DEFS_VH

// ****************************************************************
// Register addresses and reset values
// ****************************************************************
`define HMLC_ADDR_MODE_TRIG     8'h07
`define HMLC_ADDR_ACT_LOOP      8'h08
`define HMLC_RST_MODE_TRIG      8'h54
`define HMLC_RST_ACT_LOOP       8'h88
`define HMLC_READ_UNMAPPED      8'h00

// ****************************************************************
// Bus addresses
// ****************************************************************
`define HMLC_BCAST_ADDR         7'h58
`define HMLC_OWN_ADDR_DEFAULT   7'h5A

// ****************************************************************
// Field positions of the mode and trigger register
// ****************************************************************
`define HMLC_BCAST_EN_BIT       7
`define HMLC_AVG_DIS_BIT        6
`define HMLC_COMP_HI            5
`define HMLC_COMP_LO            4
`define HMLC_PIN_HI             3
`define HMLC_PIN_LO             2
`define HMLC_MODE_HI            1
`define HMLC_MODE_LO            0

// ****************************************************************
// Field positions of the actuator and loop register
// ****************************************************************
`define HMLC_ACT_TYPE_BIT       7
`define HMLC_OPEN_LOOP_BIT      6
`define HMLC_HYBRID_BIT         5
`define HMLC_OL_BRAKE_BIT       4
`define HMLC_BRK_STBY_BIT       3
`define HMLC_SLOPE_BIT          2

// ****************************************************************
// Field codes
// ****************************************************************
`define HMLC_PIN_PULSE          2'h0
`define HMLC_PIN_LEVEL          2'h1
`define HMLC_PIN_INTERRUPT      2'h2
`define HMLC_COMP_CODE0         3'h0
`define HMLC_COMP_CODE1         3'h2
`define HMLC_COMP_CODE2         3'h4
`define HMLC_COMP_CODE3         3'h5

`endif

// ---- hmlc_period_avg.v ----
// Resonance period reporting with optional four-stage running average.
`timescale 1ns/10ps
`default_nettype none

module hmlc_period_avg #(
  parameter WIDTH      = 10,
  parameter LOG2_DEPTH = 2
) (
  input  wire             clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] meas,
  input  wire             meas_valid,
  input  wire             avg_dis,
  output reg  [WIDTH-1:0] report
);

  localparam DEPTH = 1 << LOG2_DEPTH;
  localparam SUMW  = WIDTH + LOG2_DEPTH;

  wire [WIDTH-1:0] stage_reg_w [0:DEPTH];
  wire [SUMW-1:0]  part_sum    [0:DEPTH];
  wire [SUMW-1:0]  sum_full;
  wire [WIDTH-1:0] avg_value;

  assign stage_reg_w[0] = meas;
  assign part_sum[0]    = {SUMW{1'b0}};

  // ****************************************************************
  // Shift stages, cleared to zero so early averages ramp up from zero
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_stage
      reg [WIDTH-1:0] stage_reg;
      always @(posedge clk) begin
        if (rst) begin
          stage_reg <= {WIDTH{1'b0}};
        end else if (meas_valid) begin
          stage_reg <= stage_reg_w[g];
        end
      end
      assign stage_reg_w[g+1] = stage_reg;
      assign part_sum[g+1]    = part_sum[g] + {{LOG2_DEPTH{1'b0}}, stage_reg};
    end
  endgenerate

  assign sum_full  = part_sum[DEPTH];
  assign avg_value = sum_full[SUMW-1:LOG2_DEPTH];

  always @(posedge clk) begin
    if (rst) begin
      report <= {WIDTH{1'b0}};
    end else if (avg_dis) begin
      report <= stage_reg_w[1];
    end else begin
      report <= avg_value;
    end
  end

endmodule

`default_nettype wire

// ---- hmlc_config_sva.sv ----
// Port-level assertions for the configuration block.
`timescale 1ns/10ps
`default_nettype none
module hmlc_config_sva (
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       SCL,
  input wire logic       SDA_OE,
  input wire logic       TRIG_OE,
  input wire logic       INT_REQ,
  input wire logic       GO_WRITE,
  input wire logic       GO_VALUE,
  input wire logic       PROCESS_BUSY,
  input wire logic       PLAYING,
  input wire logic       STANDBY_TIMER,
  input wire logic [2:0] COMP_PERCENT,
  input wire logic       START_PULSE,
  input wire logic       CANCEL_PULSE,
  input wire logic       STANDBY_PULSE,
  input wire logic       BRAKE_REQ
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  sequence s_tmr_idle;
    STANDBY_TIMER && !PLAYING && !BRAKE_REQ;
  endsequence
  sequence s_tmr_play;
    STANDBY_TIMER && PLAYING && !BRAKE_REQ;
  endsequence
  a_comp_legal: assert property (COMP_PERCENT inside {3'h0, 3'h2, 3'h4, 3'h5})
    else $error("compensation output outside its table");
  a_timer_direct: assert property (s_tmr_idle |=> STANDBY_PULSE && !BRAKE_REQ)
    else $error("idle standby request not served at once");
  a_timer_brake: assert property (s_tmr_play |=> BRAKE_REQ || STANDBY_PULSE)
    else $error("standby request while playing ignored");
  a_brake_cause: assert property ($rose(BRAKE_REQ) |-> $past(PLAYING))
    else $error("brake started without playback");
  a_brake_end: assert property ($fell(BRAKE_REQ) |-> ##[0:2] STANDBY_PULSE)
    else $error("brake ended without standby");
  a_cancel_cause: assert property (CANCEL_PULSE |->
    $past(GO_WRITE) && !$past(GO_VALUE) && $past(PROCESS_BUSY))
    else $error("cancel without go cleared during a process");
  a_start_idle: assert property (START_PULSE |-> !$past(PROCESS_BUSY) ##1 !START_PULSE)
    else $error("start pulse while busy or too long");
  a_standby_once: assert property (STANDBY_PULSE |=> !STANDBY_PULSE)
    else $error("standby pulse longer than one cycle");
  a_int_drive: assert property (TRIG_OE |-> $past(INT_REQ))
    else $error("shared pin pulled low without interrupt");
  a_ack_timing: assert property ($changed(SDA_OE) |-> !$past(SCL))
    else $error("data line changed while clock high");
endmodule
bind hmlc_config hmlc_config_sva u_sva (.CLK, .RST, .SCL, .SDA_OE, .TRIG_OE, .INT_REQ,
  .GO_WRITE, .GO_VALUE, .PROCESS_BUSY, .PLAYING, .STANDBY_TIMER, .COMP_PERCENT,
  .START_PULSE, .CANCEL_PULSE, .STANDBY_PULSE, .BRAKE_REQ);
`default_nettype wire

// ---- hmlc_host_model.sv ----
// Two-wire bus master standing in for the host processor.
`timescale 1ns/10ps
`default_nettype none
module hmlc_host_model (
  input  wire logic clk,
  input  wire logic sda,
  output var logic  scl,
  output var logic  sda_m
);
  // ****************************************************************
  // Bus phases
  // ****************************************************************
  // The data line is pulled up, so releasing it means driving 1 here.
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // Four clocks per level keeps each phase above the two-sample minimum.
  task automatic lv(input logic c, input logic d);
    scl = c;
    sda_m = d;
    repeat (4) @(negedge clk);
  endtask
  task automatic cond(input logic a);
    lv(1'b0, sda_m);
    lv(1'b0, a);
    lv(1'b1, a);
    lv(1'b1, ~a);
  endtask
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      lv(1'b0, sda_m);
      lv(1'b0, d[i]);
      lv(1'b1, d[i]);
      q[i] = sda;
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                    output logic nak);
    logic [8:0] q0, q1, q2;
    cond(1'b1);
    xfer({a, 2'b01}, q0);
    xfer({p, 1'b1}, q1);
    xfer({d, 1'b1}, q2);
    cond(1'b0);
    nak = q0[0] | q1[0] | q2[0];
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] r);
    logic [8:0] q;
    cond(1'b1);
    xfer({a, 2'b01}, q);
    xfer({p, 1'b1}, q);
    cond(1'b1);
    xfer({a, 2'b11}, q);
    xfer(9'h1FF, q);
    cond(1'b0);
    r = q[8:1];
  endtask
endmodule
`default_nettype wire

// ---- hmlc_config_test.sv ----
// Self-checking test of the configuration block through its two-wire bus.
`timescale 1ns/10ps
`default_nettype none
module hmlc_config_test;
  logic       CLK = 1'b0, RST = 1'b1, trig_drv = 1'b0, nak;
  logic       INT_REQ = 1'b0, GO_WRITE = 1'b0, GO_VALUE = 1'b0, PROCESS_BUSY = 1'b0;
  logic       PLAYING = 1'b0, STANDBY_TIMER = 1'b0, BRAKE_DONE = 1'b0, PERIOD_VALID = 1'b0;
  logic [7:0] SAMPLE = 8'h00, q, st_n = 8'h00, cn_n = 8'h00, sb_n = 8'h00;
  logic [9:0] PERIOD_MEAS = 10'h000;
  wire        scl, sda_m, SDA_OUT, SDA_OE, TRIG_OUT, TRIG_OE, START_PULSE, CANCEL_PULSE;
  wire        STANDBY_PULSE, BRAKE_REQ, ACTUATOR_LRA, DRIVE_CLOSED_LOOP, SAMPLE_BRAKE;
  wire        HYBRID_LOOP, SLOPE_CHECK_EN;
  wire [1:0]  MODE;
  wire [2:0]  COMP_PERCENT;
  wire [9:0]  PERIOD_REPORT;
  wire        sda = SDA_OE ? (sda_m & SDA_OUT) : sda_m;
  wire        trig = TRIG_OE ? (trig_drv & TRIG_OUT) : trig_drv;
  wire [4:0]  loop_out = {ACTUATOR_LRA, DRIVE_CLOSED_LOOP, SAMPLE_BRAKE, HYBRID_LOOP,
                          SLOPE_CHECK_EN};
  int         err_count = 0, checked = 0;
  logic [7:0] av [7] = '{8'hC8, 8'h50, 8'h50, 8'h50, 8'h24, 8'h04, 8'h08};
  logic [7:0] sm [7] = '{8'h00, 8'h80, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00};
  logic [4:0] ex [7] = '{5'h10, 5'h0C, 5'h0C, 5'h00, 5'h0B, 5'h08, 5'h08};
  logic [2:0] cp [4] = '{3'h0, 3'h2, 3'h4, 3'h5};
  hmlc_config dut (.CLK, .RST, .SCL(scl), .SDA_IN(sda), .SDA_OUT, .SDA_OE, .TRIG_IN(trig),
    .TRIG_OUT, .TRIG_OE, .INT_REQ, .GO_WRITE, .GO_VALUE, .PROCESS_BUSY, .PLAYING,
    .STANDBY_TIMER, .BRAKE_DONE, .SAMPLE, .PERIOD_MEAS, .PERIOD_VALID, .PERIOD_REPORT,
    .MODE, .COMP_PERCENT, .ACTUATOR_LRA, .DRIVE_CLOSED_LOOP, .SAMPLE_BRAKE, .HYBRID_LOOP,
    .SLOPE_CHECK_EN, .START_PULSE, .CANCEL_PULSE, .STANDBY_PULSE, .BRAKE_REQ);
  hmlc_host_model host (.clk(CLK), .sda(sda), .scl(scl), .sda_m(sda_m));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  always #2.5 CLK = ~CLK;
  always @(posedge CLK) begin
    st_n <= st_n + {7'h00, START_PULSE === 1'b1};
    cn_n <= cn_n + {7'h00, CANCEL_PULSE === 1'b1};
    sb_n <= sb_n + {7'h00, STANDBY_PULSE === 1'b1};
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge CLK);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    host.wr(7'h5A, p, d, nak);
    chk(24'(nak), 24'h000000);
  endtask
  task automatic rdc(input logic [7:0] p, input logic [7:0] e);
    host.rd(7'h5A, p, q);
    chk(24'(q), 24'(e));
  endtask
  // Pulses last one cycle, then four cycles let the registered outputs settle.
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(4);
  endtask
  task automatic go(input logic v);
    GO_VALUE = v;
    pulse(GO_WRITE);
  endtask
  task automatic note(input string s);
    $display("test %s finished at %0t", s, $time);
  endtask
  task automatic results();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #300000;
    err_count++;
    results();
  end
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    cyc(10);
    RST = 1'b0;
    cyc(2);
    rdc(8'h07, 8'h54);
    rdc(8'h08, 8'h88);
    chk(24'({MODE, COMP_PERCENT, ACTUATOR_LRA, DRIVE_CLOSED_LOOP}), 24'h00000B);
    note("reset");
    wr(8'h08, 8'h88);
    for (int c = 0; c < 4; c++) begin
      wr(8'h07, {2'b01, c[1:0], 2'b01, c[1:0]});
      cyc(3);
      chk(24'({MODE, COMP_PERCENT}), 24'({c[1:0], cp[c]}));
      rdc(8'h07, {2'b01, c[1:0], 2'b01, c[1:0]});
    end
    note("modes");
    for (int i = 0; i < 7; i++) begin
      SAMPLE = sm[i];
      wr(8'h08, av[i]);
      cyc(3);
      chk(24'(loop_out), 24'(ex[i]));
    end
    rdc(8'h08, 8'h08);
    note("loop");
    host.wr(7'h30, 8'h07, 8'h00, nak);
    chk(24'(nak), 24'h000001);
    host.wr(7'h58, 8'h07, 8'h00, nak);
    chk(24'(nak), 24'h000001);
    wr(8'h07, 8'hD4);
    host.wr(7'h58, 8'h07, 8'h55, nak);
    chk(24'(nak), 24'h000000);
    rdc(8'h07, 8'h55);
    wr(8'h10, 8'hA5);
    rdc(8'h10, 8'h00);
    note("bus");
    wr(8'h07, 8'h14);
    PERIOD_MEAS = 10'h028;
    pulse(PERIOD_VALID);
    chk(24'(PERIOD_REPORT), 24'h00000A);
    repeat (3) pulse(PERIOD_VALID);
    chk(24'(PERIOD_REPORT), 24'h000028);
    wr(8'h07, 8'h54);
    PERIOD_MEAS = 10'h007;
    pulse(PERIOD_VALID);
    chk(24'(PERIOD_REPORT), 24'h000007);
    note("period");
    go(1'b1);
    chk({st_n, cn_n, sb_n}, 24'h000000);
    pulse(trig_drv);
    chk({st_n, cn_n, sb_n}, 24'h010001);
    wr(8'h07, 8'h50);
    go(1'b1);
    chk({st_n, cn_n, sb_n}, 24'h020001);
    PROCESS_BUSY = 1'b1;
    go(1'b0);
    chk({st_n, cn_n, sb_n}, 24'h020101);
    wr(8'h07, 8'h51);
    chk({st_n, cn_n, sb_n}, 24'h020102);
    wr(8'h07, 8'h59);
    chk({st_n, cn_n, sb_n}, 24'h020103);
    PROCESS_BUSY = 1'b0;
    trig_drv = 1'b1;
    pulse(INT_REQ);
    chk(24'({TRIG_OE, trig}), 24'h000001);
    INT_REQ = 1'b1;
    cyc(3);
    chk(24'({TRIG_OE, trig}), 24'h000002);
    INT_REQ = 1'b0;
    trig_drv = 1'b0;
    go(1'b1);
    wr(8'h07, 8'h5D);
    go(1'b1);
    chk({st_n, cn_n, sb_n}, 24'h030103);
    note("pins");
    wr(8'h07, 8'h54);
    PLAYING = 1'b1;
    pulse(STANDBY_TIMER);
    chk(24'({BRAKE_REQ, sb_n}), 24'h000103);
    pulse(BRAKE_DONE);
    chk(24'({BRAKE_REQ, sb_n}), 24'h000004);
    wr(8'h08, 8'h80);
    pulse(STANDBY_TIMER);
    chk(24'({BRAKE_REQ, sb_n}), 24'h000005);
    PLAYING = 1'b0;
    wr(8'h08, 8'h88);
    pulse(STANDBY_TIMER);
    chk(24'({BRAKE_REQ, sb_n}), 24'h000006);
    note("brake");
    results();
  end
endmodule
`default_nettype wire
